// ---- design/cshr_top.sv ----
// cshr_top: configurable shift register with pin controls and apb config.
// assumes pins are asynchronous to mclk and the shift clock is far slower.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cshr_top import cshr_pkg::*; #(
    parameter int REGISTER_WIDTH = CSHR_WIDTH_DEF
) (
    input wire logic mclk,                          // 100 MHz system clock
    input wire logic rst_n,                         // sync reset, active low
    input wire logic psel,                          // apb select
    input wire logic penable,                       // apb access phase
    input wire logic pwrite,                        // apb direction
    input wire logic [CSHR_ADDR_W-1:0] paddr,       // apb byte address
    input wire logic [31:0] pwdata,                 // apb write data
    output logic [31:0] prdata,                     // apb read data
    output logic pready,                            // apb ready
    output logic pslverr,                           // apb error
    input wire logic sr_clk,                        // shift clock pin
    input wire logic async_set,                     // asynchronous set pin
    input wire logic async_clr,                     // asynchronous reset pin
    input wire logic sync_set,                      // synchronous set pin
    input wire logic sync_clr,                      // synchronous reset pin
    input wire logic load_sel,                      // load/shift select
    input wire logic dir_sel,                       // left/right select
    input wire logic ser_in_left,                   // fills bit 0 on left
    input wire logic ser_in_right,                  // fills msb on right
    input wire logic [REGISTER_WIDTH-1:0] par_in,   // parallel data in
    output logic [REGISTER_WIDTH-1:0] q_out         // register contents
);
    localparam int W = REGISTER_WIDTH;
    localparam int NP = W + 9;

    logic [NP-1:0] pin_lv;
    logic [W-1:0] q_r;
    logic [W-1:0] apre_r;
    logic [W-1:0] aclr_r;
    logic [W-1:0] spre_r;
    logic [W-1:0] sclr_r;
    logic [CSHR_CTRL_W-1:0] ctrl_r;
    logic clk_d_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic clk_lv, aset_lv, aclr_lv, sset_lv, sclr_lv, ld_lv, dir_lv;
    logic serl_lv, serr_lv;
    logic [W-1:0] par_lv;
    logic trig, aset_on, aclr_on, sset_on, sclr_on, load_on, left_on;
    logic wr_acc;

    // every pin goes through the same filter so data and clock keep latency
    cshr_sync #(.WIDTH(NP)) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .din({sr_clk, async_set, async_clr, sync_set, sync_clr, load_sel,
              dir_sel, ser_in_left, ser_in_right, par_in}),
        .level_r(pin_lv)
    );

    assign {clk_lv, aset_lv, aclr_lv, sset_lv, sclr_lv, ld_lv, dir_lv,
            serl_lv, serr_lv, par_lv} = pin_lv;

    // previous shift clock level for edge detection
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            clk_d_r <= 1'b0;
        end else begin
            clk_d_r <= clk_lv;
        end
    end

    // edge choice and level decoding
    assign trig = ctrl_r[CSHR_CTRL_EDGE] ? (clk_d_r & ~clk_lv)
                                         : (clk_lv & ~clk_d_r);
    assign aset_on = cshr_active(aset_lv, ctrl_r[CSHR_CTRL_SRLV]);
    assign aclr_on = cshr_active(aclr_lv, ctrl_r[CSHR_CTRL_SRLV]);
    assign sset_on = cshr_active(sset_lv, ctrl_r[CSHR_CTRL_SRLV]);
    assign sclr_on = cshr_active(sclr_lv, ctrl_r[CSHR_CTRL_SRLV]);
    assign load_on = cshr_active(ld_lv, ctrl_r[CSHR_CTRL_LDLV]);
    assign left_on = cshr_active(dir_lv, ctrl_r[CSHR_CTRL_LFLV]);

    // the register itself; clear beats preset when both are asserted
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q_r <= CSHR_INIT_VAL[W-1:0];
        end else if (aclr_on) begin
            q_r <= aclr_r;
        end else if (aset_on) begin
            q_r <= apre_r;
        end else if (trig) begin
            if (sclr_on) begin
                q_r <= sclr_r;
            end else if (sset_on) begin
                q_r <= spre_r;
            end else if (load_on) begin
                q_r <= par_lv;
            end else if (left_on) begin
                q_r <= {q_r[W-2:0], serl_lv};
            end else begin
                q_r <= {serr_lv, q_r[W-1:1]};
            end
        end
    end

    assign q_out = q_r;

    // apb write side; zero wait states so access phase is the write edge
    assign wr_acc = psel & penable & pwrite;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_r <= CSHR_CTRL_RST;
            apre_r <= CSHR_APRE_RST[W-1:0];
            aclr_r <= CSHR_ACLR_RST[W-1:0];
            spre_r <= CSHR_SPRE_RST[W-1:0];
            sclr_r <= CSHR_SCLR_RST[W-1:0];
        end else if (wr_acc) begin
            unique case (paddr)
                CSHR_OFS_CTRL: ctrl_r <= pwdata[CSHR_CTRL_W-1:0];
                CSHR_OFS_APRE: apre_r <= pwdata[W-1:0];
                CSHR_OFS_ACLR: aclr_r <= pwdata[W-1:0];
                CSHR_OFS_SPRE: spre_r <= pwdata[W-1:0];
                CSHR_OFS_SCLR: sclr_r <= pwdata[W-1:0];
                default: ;
            endcase
        end
    end

    // read data captured in the setup cycle so it leaves a flip-flop
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (psel && !penable) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            unique case (paddr)
                CSHR_OFS_CTRL: prdata_r[CSHR_CTRL_W-1:0] <= ctrl_r;
                CSHR_OFS_APRE: prdata_r[W-1:0] <= apre_r;
                CSHR_OFS_ACLR: prdata_r[W-1:0] <= aclr_r;
                CSHR_OFS_SPRE: prdata_r[W-1:0] <= spre_r;
                CSHR_OFS_SCLR: prdata_r[W-1:0] <= sclr_r;
                CSHR_OFS_DATA: prdata_r[W-1:0] <= q_r;
                CSHR_OFS_PINS: prdata_r[8:0] <= pin_lv[NP-1:W];
                default: pslverr_r <= 1'b1;
            endcase
        end
    end

    assign pready = 1'b1;
    assign prdata = (psel & penable & ~pwrite) ? prdata_r : 32'h0000_0000;
    assign pslverr = psel & penable & pslverr_r;

    // checks on the register behaviour
    a_init_value: assert property (@(posedge mclk)
        disable iff (!rst_n)
        $rose(rst_n) |-> q_r == CSHR_INIT_VAL[W-1:0])
        else $error("register not at initial value after reset");
    a_async_clear: assert property (@(posedge mclk)
        disable iff (!rst_n)
        (aclr_lv == ctrl_r[CSHR_CTRL_SRLV]) |=> q_r == $past(aclr_r))
        else $error("async clear value not taken");
    a_async_preset: assert property (@(posedge mclk)
        disable iff (!rst_n)
        (aset_lv == ctrl_r[CSHR_CTRL_SRLV]) && !aclr_on
        |=> q_r == $past(apre_r))
        else $error("async preset value not taken");
    a_sync_clear: assert property (@(posedge mclk)
        disable iff (!rst_n)
        trig && !aclr_on && !aset_on
        && (sclr_lv == ctrl_r[CSHR_CTRL_SRLV]) |=> q_r == $past(sclr_r))
        else $error("sync clear value not taken");
    a_sync_preset: assert property (@(posedge mclk)
        disable iff (!rst_n)
        trig && !aclr_on && !aset_on && !sclr_on
        && (sset_lv == ctrl_r[CSHR_CTRL_SRLV]) |=> q_r == $past(spre_r))
        else $error("sync preset value not taken");
    a_load_data: assert property (@(posedge mclk)
        disable iff (!rst_n)
        trig && !aclr_on && !aset_on && !sclr_on && !sset_on
        && (ld_lv == ctrl_r[CSHR_CTRL_LDLV]) |=> q_r == $past(par_lv))
        else $error("parallel load missed");
    a_shift_left: assert property (@(posedge mclk)
        disable iff (!rst_n)
        trig && !aclr_on && !aset_on && !sclr_on && !sset_on && !load_on
        && (dir_lv == ctrl_r[CSHR_CTRL_LFLV])
        |=> q_r == {$past(q_r[W-2:0]), $past(serl_lv)})
        else $error("left shift wrong");
    a_shift_right: assert property (@(posedge mclk)
        disable iff (!rst_n)
        trig && !aclr_on && !aset_on && !sclr_on && !sset_on && !load_on
        && (dir_lv != ctrl_r[CSHR_CTRL_LFLV])
        |=> q_r == {$past(serr_lv), $past(q_r[W-1:1])})
        else $error("right shift wrong");
    a_edge_only: assert property (@(posedge mclk)
        disable iff (!rst_n)
        !aclr_on && !aset_on && !(ctrl_r[CSHR_CTRL_EDGE] ?
        (clk_d_r && !clk_lv) : (!clk_d_r && clk_lv)) |=> $stable(q_r))
        else $error("register moved without its edge");
    a_async_first: assert property (@(posedge mclk)
        disable iff (!rst_n)
        aclr_on && trig && sclr_on |=> q_r == $past(aclr_r))
        else $error("clocked action beat async clear");
    // a sync set at the edge must win even while the load level is active
    a_sync_first: assert property (@(posedge mclk)
        disable iff (!rst_n)
        trig && !aclr_on && !aset_on && !sclr_on && sset_on && load_on
        |=> q_r == $past(spre_r))
        else $error("load beat sync preset");
    // in falling-edge mode a rising filtered clock must leave q alone
    a_wrong_edge: assert property (@(posedge mclk)
        disable iff (!rst_n)
        ctrl_r[CSHR_CTRL_EDGE] && clk_lv && !clk_d_r && !aclr_on && !aset_on
        |=> $stable(q_r))
        else $error("register moved on the unselected edge");

    // apb side: a write lands at the access edge, value in the low bits
    a_ctrl_write: assert property (@(posedge mclk)
        disable iff (!rst_n)
        psel && penable && pwrite && paddr == CSHR_OFS_CTRL
        |=> ctrl_r == $past(pwdata[CSHR_CTRL_W-1:0]))
        else $error("control write not taken");
    a_clear_write: assert property (@(posedge mclk)
        disable iff (!rst_n)
        psel && penable && pwrite && paddr == CSHR_OFS_ACLR
        |=> aclr_r == $past(pwdata[W-1:0]))
        else $error("async clear value write not taken");
    a_bad_addr: assert property (@(posedge mclk)
        disable iff (!rst_n)
        psel && !penable && paddr > CSHR_OFS_PINS |=> pslverr_r)
        else $error("unmapped address not flagged");
endmodule // cshr_top
`default_nettype wire

// ---- design/cshr_pkg.sv ----
// cshr_pkg: constants, register map and field layout of the shift register.
// assumes an apb master on mclk and pins that are asynchronous to mclk.
// Operation
// - the register width is a parameter sizing the parallel in and out ports.
// - an edge option picks the rising or the falling edge of the shift clock.
// - a polarity option makes set and reset pins active high or active low.
// - a polarity option picks which load select level loads and which shifts.
// - a polarity option decides which direction select level shifts left.
// - an active asynchronous set forces the async preset value at once.
// - an active sync set at the clock edge forces the sync preset value.
// - an active sync reset at the clock edge forces the sync clear value.
// - the output starts from an initial value before any edge or set event.
// - an active asynchronous reset forces the async clear value at once.
`default_nettype none
package cshr_pkg;
    localparam int CSHR_WIDTH_DEF = 8;         // default register_width
    localparam int CSHR_ADDR_W = 8;            // apb byte address bits
    // register byte offsets
    localparam logic [7:0] CSHR_OFS_CTRL = 8'h00;
    localparam logic [7:0] CSHR_OFS_APRE = 8'h04; // async_preset_value
    localparam logic [7:0] CSHR_OFS_ACLR = 8'h08; // async_clear_value
    localparam logic [7:0] CSHR_OFS_SPRE = 8'h0C; // sync_preset_value
    localparam logic [7:0] CSHR_OFS_SCLR = 8'h10; // sync_clear_value
    localparam logic [7:0] CSHR_OFS_DATA = 8'h14; // register contents, ro
    localparam logic [7:0] CSHR_OFS_PINS = 8'h18; // filtered pin levels, ro
    // control field positions
    localparam int CSHR_CTRL_EDGE = 0;  // 0: rising edge, 1: falling edge
    localparam int CSHR_CTRL_SRLV = 1;  // set/reset active level
    localparam int CSHR_CTRL_LDLV = 2;  // load select level that loads
    localparam int CSHR_CTRL_LFLV = 3;  // direction level that shifts left
    localparam int CSHR_CTRL_W = 4;
    // reset values
    localparam logic [3:0] CSHR_CTRL_RST = 4'hE; // rising, all levels high
    // initial_output_value, loaded by rst_n
    localparam logic [31:0] CSHR_INIT_VAL = 32'h0000_0000;
    localparam logic [31:0] CSHR_APRE_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] CSHR_ACLR_RST = 32'h0000_0000;
    localparam logic [31:0] CSHR_SPRE_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] CSHR_SCLR_RST = 32'h0000_0000;
    localparam int CSHR_SYNC_STAGES = 3;

    // true when a pin level matches the level chosen as active
    function automatic logic cshr_active(input logic level, input logic pol);
        return level == pol;
    endfunction
endpackage
`default_nettype wire

// ---- design/cshr_sync.sv ----
// cshr_sync: three-stage synchroniser with an agreement filter per bit.
// assumes each bit is an independent asynchronous level.
`timescale 1ns/1ps
`default_nettype none
module cshr_sync import cshr_pkg::*; #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,                 // system clock
    input wire logic rst_n,                // synchronous reset, active low
    input wire logic [WIDTH-1:0] din,      // asynchronous levels
    output logic [WIDTH-1:0] level_r       // filtered level
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;

    // stage chain; s1_r is read by s2_r only, to keep metastability contained
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            level_r <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    level_r[i] <= s3_r[i];
                end
            end
        end
    end
endmodule // cshr_sync
`default_nettype wire

// ---- verif/cshr_clk_src.sv ----
// cshr_clk_src: far-side logic that makes one shift-clock pulse per request.
// assumes go is a one-cycle strobe on mclk. sr_clk stays low between pulses.
`timescale 1ns/1ps
`default_nettype none
module cshr_clk_src (
    input wire logic mclk,   // system clock
    input wire logic rst_n,  // sync reset, active low
    input wire logic go,     // request one pulse
    output logic sr_clk      // shift clock pin
);
    logic [3:0] cnt_r;
    // high six cycles, then low six; longer than the pin filter needs
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= (cnt_r == 4'hC) ? 4'h0 : cnt_r + 4'h1;
        end else if (go) begin
            cnt_r <= 4'h1;
        end
    end
    assign sr_clk = (cnt_r != 4'h0) && (cnt_r < 4'h7);
endmodule // cshr_clk_src
`default_nettype wire

// ---- verif/configurable_shift_register_tb_top.sv ----
// testbench top: apb setup plus pin scenarios on an 8-bit register.
// assumes zero-wait apb and about five mclk edges from pin to q_out.
`timescale 1ns/1ps
`default_nettype none
module configurable_shift_register_tb_top import cshr_pkg::*;;
    logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, go = 1'b0, aset = 1'b0, aclr = 1'b0;
    logic sset = 1'b0, sclr = 1'b0, ld = 1'b0, dir = 1'b0;
    logic sl = 1'b0, sr = 1'b0, pready, pslverr, sr_clk, er;
    logic [7:0] paddr = 8'h00, par = 8'h00, q;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    int err_total = 0, samples_checked = 0;
    always #5 mclk = ~mclk;
    cshr_clk_src cshr_clk_src_inst (.mclk(mclk), .rst_n(rst_n), .go(go),
        .sr_clk(sr_clk));
    cshr_top cshr_top_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sr_clk(sr_clk), .async_set(aset), .async_clr(aclr),
        .sync_set(sset), .sync_clr(sclr), .load_sel(ld), .dir_sel(dir),
        .ser_in_left(sl), .ser_in_right(sr), .par_in(par), .q_out(q));
    // verdict in one place; a timeout lands here as well
    task results;
        $display("mismatches %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            err_total++;
            $display("[ERR] pready expected 1 seen %b", pready);
            results();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // let pins pass the filter, then one shift-clock pulse and its latency
    task pulse;
        repeat (4) @(posedge mclk);
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        repeat (20) @(posedge mclk);
    endtask
    task t_reset;
        apb(1'b0, CSHR_OFS_CTRL, 32'h0); chk("ctrl", 32'h0000_000E, rd);
        apb(1'b0, CSHR_OFS_APRE, 32'h0); chk("apre", 32'h0000_00FF, rd);
        apb(1'b0, CSHR_OFS_DATA, 32'h0); chk("data", 32'h0, rd);
        apb(1'b0, 8'h40, 32'h0); chk("unmapped", 32'h1, {31'h0, er});
    endtask
    task t_load_shift;
        ld <= 1'b1; par <= 8'hA5; pulse(); chk("load", 32'hA5, {24'h0, q});
        ld <= 1'b0; dir <= 1'b1; sl <= 1'b1;
        pulse(); chk("left", 32'h4B, {24'h0, q});
        dir <= 1'b0; sr <= 1'b1;
        pulse(); chk("right", 32'hA5, {24'h0, q});
    endtask
    // falling edge, inverted load and direction levels; one edge per pulse
    task t_polarity;
        apb(1'b1, CSHR_OFS_CTRL, 32'h3);
        ld <= 1'b0; par <= 8'h3C; pulse(); chk("ld0", 32'h3C, {24'h0, q});
        ld <= 1'b1; sl <= 1'b0; pulse(); chk("lf0", 32'h78, {24'h0, q});
    endtask
    task t_sync;
        apb(1'b1, CSHR_OFS_CTRL, 32'hE);
        apb(1'b1, CSHR_OFS_SCLR, 32'h66);
        apb(1'b0, CSHR_OFS_SCLR, 32'h0);
        chk("sclr_reg", 32'h0000_0066, rd);
        par <= 8'h11; sset <= 1'b1; pulse(); chk("sset", 32'hFF, {24'h0, q});
        sclr <= 1'b1; pulse(); chk("sclr", 32'h66, {24'h0, q});
        sset <= 1'b0; sclr <= 1'b0;
    endtask
    task t_async;
        apb(1'b1, CSHR_OFS_APRE, 32'h5A);
        apb(1'b1, CSHR_OFS_ACLR, 32'h81);
        aset <= 1'b1; repeat (10) @(posedge mclk);
        chk("aset", 32'h5A, {24'h0, q});
        pulse(); chk("aset_hold", 32'h5A, {24'h0, q});
        aclr <= 1'b1; repeat (10) @(posedge mclk);
        chk("aclr", 32'h81, {24'h0, q});
        // a clocked sync clear must not get past an active async clear
        sclr <= 1'b1;
        pulse();
        chk("aclr_hold", 32'h81, {24'h0, q});
        // active-low levels: only the async set pin sits low
        aset <= 1'b0; sset <= 1'b1; sclr <= 1'b1;
        apb(1'b1, CSHR_OFS_CTRL, 32'hC); repeat (10) @(posedge mclk);
        chk("lvl0", 32'h5A, {24'h0, q});
        // filtered pins, bit 8 down: clk aset aclr sset sclr ld dir sl sr
        apb(1'b0, CSHR_OFS_PINS, 32'h0);
        chk("pins", 32'h0000_0079, rd);
    endtask
    // second reset mid-run: set and reset pins idle, then the initial value must return
    task t_rst;
        aclr <= 1'b0;
        sset <= 1'b0;
        sclr <= 1'b0;
        rst_n <= 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        apb(1'b0, CSHR_OFS_DATA, 32'h0);
        chk("data_rst", 32'h0, rd);
        apb(1'b0, CSHR_OFS_CTRL, 32'h0);
        chk("ctrl_rst", 32'h0000_000E, rd);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_load_shift();
        t_polarity();
        t_sync();
        t_async();
        t_rst();
        results();
    end
endmodule // configurable_shift_register_tb_top
`default_nettype wire
